// ===== pmic_cfg_pkg.sv
// Constants, timing figures and state type of the shutdown and key configuration block
package pmic_cfg_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [11:0] IDX_BUCK_MOTOR   = 12'h10D;
	localparam logic [11:0] IDX_OFF_SOURCE   = 12'h10E;
	localparam logic [11:0] IDX_RESET_KEY    = 12'h10F;
	localparam logic [13:0] ADDR_BUCK_MOTOR  = {IDX_BUCK_MOTOR, 2'b00};
	localparam logic [13:0] ADDR_OFF_SOURCE  = {IDX_OFF_SOURCE, 2'b00};
	localparam logic [13:0] ADDR_RESET_KEY   = {IDX_RESET_KEY, 2'b00};
	localparam logic [7:0]  RST_BUCK_MOTOR   = 8'h00;
	localparam logic [7:0]  RST_OFF_SOURCE   = 8'h00;
	localparam logic [7:0]  RST_RESET_KEY    = 8'h00;

	// Field positions, first register
	localparam int BIT_MEMIO_JOIN   = 7;
	localparam int BIT_CORE_A_FULL  = 6;
	localparam int BIT_CORE_B_FULL  = 5;
	localparam int BIT_PROC_FULL    = 4;
	localparam int BIT_CORE_JOIN    = 3;
	localparam int BIT_SENSE_ROUTE  = 2;
	localparam int BIT_MOTOR_SEL    = 1;
	localparam int BIT_PWM_SLOW     = 0;
	// Field positions, second register
	localparam int BIT_LIN_OC_OFF   = 7;
	localparam int BIT_FAULT_SPEED  = 6;
	localparam int BIT_HOST_SPEED   = 5;
	localparam int BIT_USER_SPEED   = 4;
	localparam int BIT_DUAL_OFF     = 3;
	localparam int BIT_KEY_HOLD_OFF = 2;
	localparam int POS_KEY_PIN      = 0;
	// Field positions, third register
	localparam int BIT_IF_RESET     = 7;
	localparam int BIT_SERIAL_TO    = 6;
	localparam int POS_RESET_DUR    = 4;
	localparam int POS_SHUT_DELAY   = 2;
	localparam int POS_KEY_DELAY    = 0;

	// Key pin function codes
	localparam logic [1:0] KEY_PORT_MODE = 2'h0;

	// Clock and time base
	localparam int CLK_PERIOD_NS    = 20;
	localparam int CLK_HZ           = 50_000_000;
	localparam int MS_IN_NS         = 1_000_000;
	localparam int CYC_PER_MS_DFLT  = MS_IN_NS / CLK_PERIOD_NS;
	localparam int PWM_FAST_KHZ     = 2000;
	localparam int PWM_SLOW_KHZ     = 1000;
	localparam logic [5:0] PWM_FAST_DIV = 6'(CLK_HZ / (PWM_FAST_KHZ * 1000));
	localparam logic [5:0] PWM_SLOW_DIV = 6'(CLK_HZ / (PWM_SLOW_KHZ * 1000));

	// Durations in milliseconds or seconds, as printed
	localparam int LDO_LIMIT_MS     = 200;
	localparam int SCL_STALL_MS     = 19;
	localparam int RESET_DUR0_MS    = 20;
	localparam int RESET_DUR1_MS    = 100;
	localparam int RESET_DUR2_MS    = 500;
	localparam int RESET_DUR3_MS    = 1000;
	localparam int KEY_DELAY0_MS    = 1000;
	localparam int KEY_DELAY1_MS    = 1500;
	localparam int KEY_DELAY2_MS    = 2000;
	localparam int KEY_DELAY3_MS    = 7000;
	localparam int SHUT_ADD1_S      = 4;
	localparam int SHUT_ADD2_S      = 5;
	localparam int SHUT_ADD3_S      = 6;
	localparam int MS_PER_S         = 1000;

	// Number of supervised linear regulators
	localparam int LIN_CNT          = 5;

	// Whole state of the block
	typedef struct packed {
		logic [7:0]            cfg_h;
		logic [7:0]            cfg_i;
		logic [7:0]            cfg_j;
		logic                  wait_req;
		logic [7:0]            rdata;
		logic [15:0]           ms_div;
		logic                  ms_tick;
		logic [5:0]            pwm_div;
		logic                  pwm_tick;
		logic [1:0]            key_s;
		logic [1:0]            g14_s;
		logic [1:0]            g15_s;
		logic [1:0]            offn_s;
		logic [1:0]            scl_s;
		logic                  offn_d;
		logic                  scl_d;
		logic [LIN_CNT-1:0]    lim_s1;
		logic [LIN_CNT-1:0]    lim_s2;
		logic [LIN_CNT-1:0][7:0] lim_ms;
		logic [LIN_CNT-1:0]    lin_off;
		logic [13:0]           key_ms;
		logic [13:0]           gpi_ms;
		logic [4:0]            scl_ms;
		logic [10:0]           rst_ms;
		logic                  reset_hold;
		logic                  sense_fb;
		logic                  sense_sw;
		logic                  off_start;
		logic                  off_fast;
		logic                  por_pulse;
		logic                  lock_evt;
		logic                  iface_rst;
		logic                  tw_rst;
	} state_t;

endpackage

// ===== pmic_shutdown_key_config.sv
// Configuration, shutdown source and power key timing logic
`timescale 1ns/1ps
// Summary of operation
// - Memory/IO join disables IO converter control
// - Full-current bits switch three converters
// - Core join makes one dual-phase converter
// - Sense route picks feedback or switch pin
// - Mode bit picks regulator or motor driver
// - PWM clock 2 MHz or 1 MHz
// - Overcurrent over 200 ms switches regulators off
// - Fault shutdown normal or fast
// - Host shutdown normal or fast
// - User shutdown may force power-on reset
// - After reset wait duration before power-up
// - Both inputs 14 and 15 may shut down
// - Long key press may shut down
// - Key pin function decoded from two bits
// - Off pin may reset control interfaces
// - Serial clock stall over 19 ms resets
// - Reset mode lasts 20 to 1000 ms
// - Shutdown threshold is lock delay plus offset
// - Key lock after 1 to 7 s
module pmic_shutdown_key_config
	import pmic_cfg_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = CYC_PER_MS_DFLT  // Cycles per ms
) (
	input  wire logic               clk,                 // System clock
	input  wire logic               rst,                 // Sync reset
	input  wire logic [13:0]        address,             // Byte address
	input  wire logic               read,                // Read strobe
	input  wire logic               write,               // Write strobe
	input  wire logic [31:0]        writedata,           // Write data
	input  wire logic [3:0]         byteenable,          // Byte lanes
	output logic      [31:0]        readdata,            // Read data
	output logic                    waitrequest,         // Slave stall
	input  wire logic               power_key_n,         // Key pin
	input  wire logic               gpi14,               // Input 14 pin
	input  wire logic               gpi15,               // Input 15 pin
	input  wire logic               off_request_n,       // Off pin
	input  wire logic               scl,                 // Serial clock pin
	input  wire logic [LIN_CNT-1:0] lin_limit,           // Current limit flags
	input  wire logic               remote_sense,        // Remote sense on
	input  wire logic               fault_off,           // Internal fault
	input  wire logic               host_off,            // Register off bit
	input  wire logic               reset_entry,         // Reset mode start
	output logic                    memio_pair_join,     // Joined coil
	output logic                    io_ctrl_disable,     // IO regs ignored
	output logic                    core_a_full_current, // Full current A
	output logic                    core_b_full_current, // Full current B
	output logic                    processor_rail_full_current, // Full
	output logic                    core_pair_join,      // Dual phase
	output logic                    core_b_ctrl_disable, // B regs ignored
	output logic                    feedback_pin_two_taken, // Sense on fb
	output logic                    core_switch_pd_off,  // Sense on switch
	output logic                    motor_regulator_select, // Motor mode
	output logic                    pwm_tick,            // PWM clock pulse
	output logic [LIN_CNT-1:0]      linear_off,          // Regulator off
	output logic                    off_start,           // Start shutdown
	output logic                    off_fast,            // Fast sequence
	output logic                    por_pulse,           // Power-on reset
	output logic                    key_locked_event,    // Lock pulse
	output logic [1:0]              key_pin_function,    // Key mode code
	output logic                    iface_reset,         // Interfaces reset
	output logic                    serial_stall_reset,  // Two-wire reset
	output logic                    reset_hold           // Power-up blocked
);

	state_t st_r;
	state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Threshold lookups

	function automatic logic [10:0] reset_ms(input logic [1:0] code);
		unique case (code)
			2'h0: reset_ms = 11'(RESET_DUR0_MS);
			2'h1: reset_ms = 11'(RESET_DUR1_MS);
			2'h2: reset_ms = 11'(RESET_DUR2_MS);
			2'h3: reset_ms = 11'(RESET_DUR3_MS);
		endcase
	endfunction

	function automatic logic [13:0] lock_ms(input logic [1:0] code);
		unique case (code)
			2'h0: lock_ms = 14'(KEY_DELAY0_MS);
			2'h1: lock_ms = 14'(KEY_DELAY1_MS);
			2'h2: lock_ms = 14'(KEY_DELAY2_MS);
			2'h3: lock_ms = 14'(KEY_DELAY3_MS);
		endcase
	endfunction

	function automatic logic [13:0] shut_ms(input logic [1:0] sc,
	                                        input logic [1:0] kc);
		logic [13:0] add;
		add = 14'h0000;
		unique case (sc)
			2'h0: add = 14'h0000;
			2'h1: add = 14'(SHUT_ADD1_S * MS_PER_S);
			2'h2: add = 14'(SHUT_ADD2_S * MS_PER_S);
			2'h3: add = 14'(SHUT_ADD3_S * MS_PER_S);
		endcase
		shut_ms = lock_ms(kc) + add;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		logic       sel;
		logic       off_fall;
		logic       key_dn;
		logic       dual_dn;
		logic       user_off;
		logic [1:0] kc;
		logic [1:0] sc;
		st_nxt   = st_r;
		sel      = 1'b0;
		off_fall = 1'b0;
		key_dn   = 1'b0;
		dual_dn  = 1'b0;
		user_off = 1'b0;
		kc       = st_r.cfg_j[POS_KEY_DELAY +: 2];
		sc       = st_r.cfg_j[POS_SHUT_DELAY +: 2];

		// Pulses default low
		st_nxt.off_start = 1'b0;
		st_nxt.por_pulse = 1'b0;
		st_nxt.lock_evt  = 1'b0;
		st_nxt.iface_rst = 1'b0;
		st_nxt.tw_rst    = 1'b0;

		// Two-stage synchronisers for every pin
		st_nxt.key_s  = {st_r.key_s[0], power_key_n};
		st_nxt.g14_s  = {st_r.g14_s[0], gpi14};
		st_nxt.g15_s  = {st_r.g15_s[0], gpi15};
		st_nxt.offn_s = {st_r.offn_s[0], off_request_n};
		st_nxt.scl_s  = {st_r.scl_s[0], scl};
		st_nxt.lim_s1 = lin_limit;
		st_nxt.lim_s2 = st_r.lim_s1;
		st_nxt.offn_d = st_r.offn_s[1];
		st_nxt.scl_d  = st_r.scl_s[1];
		off_fall      = st_r.offn_d & ~st_r.offn_s[1];

		// Bus slave: one wait cycle, then a single low cycle of waitrequest
		sel = st_r.wait_req & (read | write);
		if (sel) begin
			st_nxt.wait_req = 1'b0;
			unique case (address)
				ADDR_BUCK_MOTOR: st_nxt.rdata = st_r.cfg_h;
				ADDR_OFF_SOURCE: st_nxt.rdata = st_r.cfg_i;
				ADDR_RESET_KEY:  st_nxt.rdata = st_r.cfg_j;
				default:         st_nxt.rdata = 8'h00;
			endcase
		end else if (!st_r.wait_req) begin
			st_nxt.wait_req = 1'b1;
			// Write lands on the edge that sees waitrequest low
			if (write && byteenable[0]) begin
				unique case (address)
					ADDR_BUCK_MOTOR: st_nxt.cfg_h = writedata[7:0];
					ADDR_OFF_SOURCE: st_nxt.cfg_i = writedata[7:0];
					ADDR_RESET_KEY:  st_nxt.cfg_j = writedata[7:0];
					default:         st_nxt.cfg_h = st_r.cfg_h;
				endcase
			end
		end

		// Millisecond time base shared by all slow timers
		st_nxt.ms_tick = 1'b0;
		if (st_r.ms_div >= 16'(CYC_PER_MS - 1)) begin
			st_nxt.ms_div  = 16'h0000;
			st_nxt.ms_tick = 1'b1;
		end else begin
			st_nxt.ms_div = st_r.ms_div + 16'h0001;
		end

		st_nxt.pwm_tick = 1'b0;
		if (st_r.pwm_div >= (st_r.cfg_h[BIT_PWM_SLOW] ?
		                     PWM_SLOW_DIV : PWM_FAST_DIV) - 6'h01) begin
			st_nxt.pwm_div  = 6'h00;
			st_nxt.pwm_tick = 1'b1;
		end else begin
			st_nxt.pwm_div = st_r.pwm_div + 6'h01;
		end

		// Sense routing, valid only when joined and remote sensed
		st_nxt.sense_fb = st_r.cfg_h[BIT_CORE_JOIN] & remote_sense &
		                  ~st_r.cfg_h[BIT_SENSE_ROUTE];
		st_nxt.sense_sw = st_r.cfg_h[BIT_CORE_JOIN] & remote_sense &
		                  st_r.cfg_h[BIT_SENSE_ROUTE];

		for (int n = 0; n < LIN_CNT; n++) begin
			if (!st_r.lim_s2[n]) begin
				st_nxt.lim_ms[n] = 8'h00;
			end else if (st_r.ms_tick && st_r.lim_ms[n] != 8'hFF) begin
				st_nxt.lim_ms[n] = st_r.lim_ms[n] + 8'h01;
			end
			// One extra tick covers the partial first millisecond
			if (st_r.cfg_i[BIT_LIN_OC_OFF] &&
			    st_r.lim_ms[n] > 8'(LDO_LIMIT_MS)) begin
				st_nxt.lin_off[n] = 1'b1;
			end
		end

		key_dn  = ~st_r.key_s[1] &
		          (st_r.cfg_i[POS_KEY_PIN +: 2] != KEY_PORT_MODE);
		dual_dn = st_r.g14_s[1] & st_r.g15_s[1];
		if (!key_dn) begin
			st_nxt.key_ms = 14'h0000;
		end else if (st_r.ms_tick && st_r.key_ms != 14'h3FFF) begin
			st_nxt.key_ms = st_r.key_ms + 14'h0001;
		end
		if (!dual_dn) begin
			st_nxt.gpi_ms = 14'h0000;
		end else if (st_r.ms_tick && st_r.gpi_ms != 14'h3FFF) begin
			st_nxt.gpi_ms = st_r.gpi_ms + 14'h0001;
		end

		// Lock pulse once, when the lock delay is reached
		if (key_dn && st_r.ms_tick && st_r.key_ms == lock_ms(kc) - 14'h0001)
		begin
			st_nxt.lock_evt = 1'b1;
		end

		if (key_dn && st_r.cfg_i[BIT_KEY_HOLD_OFF] && st_r.ms_tick &&
		    st_r.key_ms == shut_ms(sc, kc) - 14'h0001) begin
			user_off = 1'b1;
		end
		if (dual_dn && st_r.cfg_i[BIT_DUAL_OFF] && st_r.ms_tick &&
		    st_r.gpi_ms == shut_ms(sc, kc) - 14'h0001) begin
			user_off = 1'b1;
		end

		// Shutdown source priority: user, host, fault
		if (user_off) begin
			if (st_r.cfg_i[BIT_USER_SPEED]) begin
				st_nxt.por_pulse = 1'b1;
			end else begin
				st_nxt.off_start = 1'b1;
				st_nxt.off_fast  = 1'b0;
			end
		end else if (host_off || off_fall) begin
			st_nxt.off_start = 1'b1;
			st_nxt.off_fast  = st_r.cfg_i[BIT_HOST_SPEED];
		end else if (fault_off) begin
			st_nxt.off_start = 1'b1;
			st_nxt.off_fast  = st_r.cfg_i[BIT_FAULT_SPEED];
		end

		// Interface reset on off pin assertion
		if (off_fall && st_r.cfg_j[BIT_IF_RESET]) begin
			st_nxt.iface_rst = 1'b1;
		end

		if (st_r.scl_s[1] != st_r.scl_d) begin
			st_nxt.scl_ms = 5'h00;
		end else if (st_r.ms_tick && st_r.scl_ms <= 5'(SCL_STALL_MS)) begin
			st_nxt.scl_ms = st_r.scl_ms + 5'h01;
			if (st_r.scl_ms == 5'(SCL_STALL_MS) && st_r.cfg_j[BIT_SERIAL_TO])
			begin
				st_nxt.tw_rst = 1'b1;
			end
		end

		// Reset mode hold; POR also clears overcurrent latches
		if (reset_entry || st_nxt.por_pulse) begin
			st_nxt.rst_ms     = 11'h000;
			st_nxt.reset_hold = 1'b1;
			st_nxt.lin_off    = '0;
		end else if (st_r.reset_hold && st_r.ms_tick) begin
			st_nxt.rst_ms = st_r.rst_ms + 11'h001;
			if (st_r.rst_ms >= reset_ms(st_r.cfg_j[POS_RESET_DUR +: 2])) begin
				st_nxt.reset_hold = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r          <= '0;
			st_r.cfg_h    <= RST_BUCK_MOTOR;
			st_r.cfg_i    <= RST_OFF_SOURCE;
			st_r.cfg_j    <= RST_RESET_KEY;
			st_r.wait_req <= 1'b1;
			st_r.key_s    <= 2'h3;
			st_r.offn_s   <= 2'h3;
			st_r.offn_d   <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from state flops

	assign readdata               = {24'h000000, st_r.rdata};
	assign waitrequest            = st_r.wait_req;
	assign memio_pair_join        = st_r.cfg_h[BIT_MEMIO_JOIN];
	assign io_ctrl_disable        = st_r.cfg_h[BIT_MEMIO_JOIN];
	assign core_a_full_current    = st_r.cfg_h[BIT_CORE_A_FULL];
	assign core_b_full_current    = st_r.cfg_h[BIT_CORE_B_FULL];
	assign processor_rail_full_current = st_r.cfg_h[BIT_PROC_FULL];
	assign core_pair_join         = st_r.cfg_h[BIT_CORE_JOIN];
	assign core_b_ctrl_disable    = st_r.cfg_h[BIT_CORE_JOIN];
	assign feedback_pin_two_taken = st_r.sense_fb;
	assign core_switch_pd_off     = st_r.sense_sw;
	assign motor_regulator_select = st_r.cfg_h[BIT_MOTOR_SEL];
	assign pwm_tick               = st_r.pwm_tick;
	assign linear_off             = st_r.lin_off;
	assign off_start              = st_r.off_start;
	assign off_fast               = st_r.off_fast;
	assign por_pulse              = st_r.por_pulse;
	assign key_locked_event       = st_r.lock_evt;
	// Key pin function code to the key logic
	assign key_pin_function       = st_r.cfg_i[POS_KEY_PIN +: 2];
	assign iface_reset            = st_r.iface_rst;
	assign serial_stall_reset     = st_r.tw_rst;
	assign reset_hold             = st_r.reset_hold;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	// Helper for the PWM period check: cycles since the last tick. A long
	// repetition would be unrolled by the tools, so a counter is used.
	logic [6:0] pwm_gap_r;
	logic       pwm_slow_seen_r;
	logic       pwm_armed_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			pwm_gap_r       <= 7'h00;
			pwm_slow_seen_r <= 1'b1;
			pwm_armed_r     <= 1'b0;
		end else if (pwm_tick) begin
			pwm_gap_r       <= 7'h01;
			pwm_slow_seen_r <= st_r.cfg_h[BIT_PWM_SLOW];
			pwm_armed_r     <= 1'b1;
		end else begin
			if (pwm_gap_r != 7'h7F) begin
				pwm_gap_r <= pwm_gap_r + 7'h01;
			end
			pwm_slow_seen_r <= pwm_slow_seen_r | st_r.cfg_h[BIT_PWM_SLOW];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_BUS_ONE_LOW: assert property (
		!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_WRITE_LANDS: assert property (
		(!waitrequest && write && byteenable[0] && address == ADDR_BUCK_MOTOR)
		|=> io_ctrl_disable == $past(writedata[BIT_MEMIO_JOIN]))
		else $error("write did not update join bit");
	AST_CORE_JOIN: assert property (
		core_b_ctrl_disable == core_pair_join)
		else $error("core B control not disabled with join");
	AST_SENSE_EXCL: assert property (
		!(feedback_pin_two_taken && core_switch_pd_off))
		else $error("sense routed to both pins");
	AST_PWM_FAST: assert property (
		pwm_tick && pwm_armed_r && !pwm_slow_seen_r |->
		pwm_gap_r == {1'b0, PWM_FAST_DIV})
		else $error("fast PWM period wrong");
	AST_LIN_OFF_EN: assert property (
		$rose(linear_off) && !$past(reset_entry) |->
		$past(st_r.cfg_i[BIT_LIN_OC_OFF]))
		else $error("regulator off without enable");
	AST_HOST_FAST: assert property (
		(host_off && !fault_off && st_r.cfg_i[BIT_HOST_SPEED] &&
		 !$past(key_locked_event)) ##1 !por_pulse && off_start
		|-> off_fast)
		else $error("host shutdown speed not applied");
	AST_IF_RESET: assert property (
		iface_reset |-> $past(st_r.cfg_j[BIT_IF_RESET]))
		else $error("interface reset while disabled");
	AST_TW_RESET: assert property (
		serial_stall_reset |-> $past(st_r.cfg_j[BIT_SERIAL_TO]) &&
		st_r.scl_ms == 5'(SCL_STALL_MS + 1))
		else $error("serial reset at wrong time");
	AST_HOLD_START: assert property (
		por_pulse |-> reset_hold ##1 reset_hold)
		else $error("reset hold not raised after POR");
	AST_RELEASE_CLR: assert property (
		st_r.key_s[1] |=> st_r.key_ms == 14'h0000)
		else $error("press timer not cleared on release");

	COV_WRITE: cover property (!waitrequest && write);
	COV_LOCK: cover property (key_locked_event);
	COV_USER_POR: cover property (por_pulse);
	COV_HOLD_END: cover property ($fell(reset_hold));

endmodule

// ===== pmic_field_model.sv
// Far-side model: power key, inputs 14 and 15, off pin, serial clock, limits
`timescale 1ns/1ps
module pmic_field_model
	import pmic_cfg_pkg::*;
(
	input  wire logic               clk,           // System clock
	input  wire logic               key_press,     // Key held down
	input  wire logic               dual_press,    // Inputs 14, 15 held
	input  wire logic               off_req,       // Off pin pulled low
	input  wire logic               scl_run,       // Serial clock running
	input  wire logic [LIN_CNT-1:0] limit_req,     // Regulators in limit
	output logic                    power_key_n,   // Key pin
	output logic                    gpi14,         // Input 14 pin
	output logic                    gpi15,         // Input 15 pin
	output logic                    off_request_n, // Off pin
	output logic                    scl,           // Serial clock pin
	output logic [LIN_CNT-1:0]      lin_limit      // Limit flags
);
	logic [3:0] div;
	////////////////////////////////////////////////////////////////////////
	// Released key and off pins rest at their pull-up level
	initial begin
		{power_key_n, gpi14, gpi15, off_request_n, scl} = 5'h13;
		lin_limit = '0;
		div = 4'h0;
	end
	// Pins move just after the edge; a stalled clock stands still
	always @(posedge clk) begin
		power_key_n   <= !key_press;
		gpi14         <= dual_press;
		gpi15         <= dual_press;
		off_request_n <= !off_req;
		lin_limit     <= limit_req;
		div           <= (div == 4'h9) ? 4'h0 : div + 4'h1;
		if (scl_run && div == 4'h9) begin
			scl <= !scl;
		end
	end
endmodule

// ===== tb_pmic_shutdown_key_config.sv
// Testbench of the shutdown source and power key configuration block
`timescale 1ns/1ps
module tb_pmic_shutdown_key_config;
	import pmic_cfg_pkg::*;
	localparam int CYC_PER_MS = 10; // Short ms keeps long presses affordable
	logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
	logic [13:0] address = '0;
	logic [31:0] writedata = '0, readdata;
	logic [3:0]  byteenable = 4'hF;
	logic remote_sense = 1'b0, fault_off = 1'b0, host_off = 1'b0;
	logic reset_entry = 1'b0, key_press = 1'b0, dual_press = 1'b0;
	logic off_req = 1'b0, scl_run = 1'b1;
	logic [LIN_CNT-1:0] limit_req = '0, lin_limit, linear_off;
	logic waitrequest, memio_pair_join, io_ctrl_disable, core_a_full_current;
	logic core_b_full_current, processor_rail_full_current, core_pair_join;
	logic core_b_ctrl_disable, feedback_pin_two_taken, core_switch_pd_off;
	logic motor_regulator_select, pwm_tick, off_start, off_fast, por_pulse;
	logic key_locked_event, iface_reset, serial_stall_reset, reset_hold;
	logic power_key_n, gpi14, gpi15, off_request_n, scl;
	logic [1:0] key_pin_function;
	logic [31:0] q;
	int error_cnt = 0, comparisons = 0, n;
	int dur[4] = '{RESET_DUR0_MS, RESET_DUR1_MS, RESET_DUR2_MS, RESET_DUR3_MS};
	wire [7:0] ev = {pwm_tick, !reset_hold, linear_off[0], off_start,
		por_pulse, key_locked_event, iface_reset, serial_stall_reset};
	////////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz
	initial begin
		forever #10 clk = !clk;
	end
	pmic_shutdown_key_config #(.CYC_PER_MS(CYC_PER_MS)) i_pmic_shutdown_key_config (
		.clk, .rst, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .power_key_n, .gpi14, .gpi15, .off_request_n,
		.scl, .lin_limit, .remote_sense, .fault_off, .host_off, .reset_entry,
		.memio_pair_join, .io_ctrl_disable, .core_a_full_current,
		.core_b_full_current, .processor_rail_full_current, .core_pair_join,
		.core_b_ctrl_disable, .feedback_pin_two_taken, .core_switch_pd_off,
		.motor_regulator_select, .pwm_tick, .linear_off, .off_start,
		.off_fast, .por_pulse, .key_locked_event, .key_pin_function,
		.iface_reset, .serial_stall_reset, .reset_hold);
	pmic_field_model i_pmic_field_model (.clk, .key_press, .dual_press,
		.off_req, .scl_run, .limit_req, .power_key_n, .gpi14, .gpi15,
		.off_request_n, .scl, .lin_limit);
	////////////////////////////////////////////////////////////////////////
	// Comparison, bus access and event wait
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest is sampled low at an edge
	task automatic acc(input logic w, input logic [13:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= {24'h0, d};
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) error_cnt++;
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic rdc(input logic [13:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(q, {24'h0, e});
	endtask
	// Counts edges until the chosen event is seen, or the limit
	task automatic wt(input int s, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ev[s] !== 1'b1 && n < lim);
	endtask
	function automatic logic near(input int v, input int e);
		return v >= e - 15 && v <= e + 15;
	endfunction
	task automatic kick(input logic fault, input logic f);
		if (fault) fault_off <= 1'b1;
		else host_off <= 1'b1;
		@(posedge clk);
		fault_off <= 1'b0;
		host_off <= 1'b0;
		wt(4, 10);
		@(posedge clk);
		chk({n < 10, off_fast}, {1'b1, f});
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog well beyond the longest expected run
	initial begin
		repeat (95000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end
	// Test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(ADDR_BUCK_MOTOR, RST_BUCK_MOTOR);
		rdc(ADDR_OFF_SOURCE, RST_OFF_SOURCE);
		rdc(ADDR_RESET_KEY, RST_RESET_KEY);
		acc(1'b1, 14'h440, 8'hFF);
		rdc(14'h440, 8'h00);
		// Each converter bit alone drives only its own outputs
		for (int k = 0; k < 8; k++) begin
			acc(1'b1, ADDR_BUCK_MOTOR, 8'h01 << k);
			rdc(ADDR_BUCK_MOTOR, 8'h01 << k);
			chk({memio_pair_join, io_ctrl_disable, core_a_full_current,
				core_b_full_current, processor_rail_full_current, core_pair_join,
				core_b_ctrl_disable, motor_regulator_select}, {k == 7, k == 7,
				k == 6, k == 5, k == 4, k == 3, k == 3, k == 1});
		end
		// Lane zero disabled: write must be dropped
		byteenable <= 4'h0;
		acc(1'b1, ADDR_BUCK_MOTOR, 8'h00);
		byteenable <= 4'hF;
		rdc(ADDR_BUCK_MOTOR, 8'h80);
		// sense routing, host avoids invalid feedback codes
		remote_sense <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			acc(1'b1, ADDR_BUCK_MOTOR, 8'h08 | 8'(s << 2));
			repeat (2) @(posedge clk);
			chk({feedback_pin_two_taken, core_switch_pd_off}, 2'h2 >> s);
		end
		// PWM tick spacing for both clock choices
		for (int s = 0; s < 2; s++) begin
			acc(1'b1, ADDR_BUCK_MOTOR, 8'(s));
			wt(7, 100);
			wt(7, 100);
			chk(n, 25 + 25 * s);
		end
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, ADDR_OFF_SOURCE, 8'(c));
			@(posedge clk);
			chk(key_pin_function, 32'(c));
		end
		// Host and fault speeds set apart so a swap shows
		for (int s = 0; s < 2; s++) begin
			acc(1'b1, ADDR_OFF_SOURCE, 8'h20 << s);
			kick(1'b0, s == 0);
			kick(1'b1, s == 1);
		end
		for (int s = 1; s >= 0; s--) begin
			acc(1'b1, ADDR_RESET_KEY, 8'(s << 7));
			off_req <= 1'b1;
			wt(1, 12);
			chk(n < 12, s);
			off_req <= 1'b0;
		end
		// Running clock never trips the stall timer; a stopped one does
		acc(1'b1, ADDR_RESET_KEY, 8'h40);
		wt(0, 300);
		chk(n, 300);
		scl_run <= 1'b0;
		wt(0, 300);
		chk(n >= 185 && n <= 215, 1);
		scl_run <= 1'b1;
		acc(1'b1, ADDR_OFF_SOURCE, 8'h80);
		limit_req <= 5'h01;
		wt(5, 2100);
		chk(near(n, LDO_LIMIT_MS * CYC_PER_MS + 10), 1);
		chk(linear_off, 5'h01);
		limit_req <= 5'h00;
		for (int c = 0; c < 4; c++) begin
			acc(1'b1, ADDR_RESET_KEY, 8'(c << 4));
			reset_entry <= 1'b1;
			@(posedge clk);
			reset_entry <= 1'b0;
			wt(6, 11000);
			chk(near(n, (dur[c] + 1) * CYC_PER_MS), 1);
		end
		// short press then full press restarts the count
		acc(1'b1, ADDR_RESET_KEY, 8'h00);
		acc(1'b1, ADDR_OFF_SOURCE, 8'h05);
		key_press <= 1'b1;
		repeat (KEY_DELAY0_MS * CYC_PER_MS / 2) @(posedge clk);
		key_press <= 1'b0;
		repeat (40) @(posedge clk);
		key_press <= 1'b1;
		wt(2, 10200);
		chk(near(n, KEY_DELAY0_MS * CYC_PER_MS), 1);
		chk(off_start, 1);
		key_press <= 1'b0;
		acc(1'b1, ADDR_RESET_KEY, 8'h01);
		acc(1'b1, ADDR_OFF_SOURCE, 8'h01);
		key_press <= 1'b1;
		wt(2, 15200);
		chk(near(n, KEY_DELAY1_MS * CYC_PER_MS), 1);
		wt(4, 20);
		chk(n, 20);
		key_press <= 1'b0;
		// user shutdown as power-on reset, then reset wait
		acc(1'b1, ADDR_RESET_KEY, 8'h00);
		acc(1'b1, ADDR_OFF_SOURCE, 8'h15);
		key_press <= 1'b1;
		wt(3, 10200);
		chk(near(n, KEY_DELAY0_MS * CYC_PER_MS), 1);
		wt(6, 400);
		chk(near(n, (RESET_DUR0_MS + 1) * CYC_PER_MS), 1);
		key_press <= 1'b0;
		// Dual input path works with the key in port mode
		acc(1'b1, ADDR_OFF_SOURCE, 8'h08);
		dual_press <= 1'b1;
		wt(4, 10200);
		chk(near(n, KEY_DELAY0_MS * CYC_PER_MS), 1);
		dual_press <= 1'b0;
		tally_and_finish;
	end
endmodule
